// ---- core/cabe_core.sv ----
// Purpose: execute arithmetic, logic, multiply, jump, call and compare operations
// Assumes: operands valid with start_i while ready_o is high
// Notes: results, flags and pc commit at the end of the last cycle
// Behaviour
// - add registers, optional carry, one cycle
// - add constant to register pair, two cycles
// - subtract constant from register pair, two cycles
// - subtract register or constant, one cycle
// - borrow variants also subtract carry flag
// - logic, increment, decrement keep carry, invert sets it, one cycle
// - set bits ORs, clear bits ANDs inverse
// - test ANDs, clear XORs, ones leave flags
// - multiplies write product to R1:R0, two cycles
// - fractional multiplies shift product left once
// - indirect jump loads pc from Z, two cycles
// - indirect call pushes, loads Z, three cycles
// - compare skip equal, one to three cycles
// - compares set flags without storing, one cycle
`timescale 1ns/100ps
`include "cabe_regs.svh"
module cabe_core
    import cabe_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic start_i,
    input wire cabe_op_t op_i,
    input wire logic [7:0] rd_i,
    input wire logic [7:0] rr_i,
    input wire logic [7:0] rd_hi_i,
    input wire logic [7:0] imm_i,
    input wire logic [15:0] k_i,
    input wire logic [15:0] z_i,
    input wire logic [15:0] pop_data_i,
    input wire logic skip_two_i,
    output logic ready_o,
    output logic done_o,
    output logic rd_wr_o,
    output logic [7:0] rd_data_o,
    output logic word_wr_o,
    output logic prod_wr_o,
    output logic [15:0] word_data_o,
    output logic push_o,
    output logic [15:0] push_data_o,
    output logic pop_o,
    output logic [7:0] sreg_o,
    output logic [15:0] pc_o
);
    cabe_state_t state;
    logic [2:0] cnt;
    logic [2:0] next_cyc;
    cabe_commit_t next_c;
    cabe_commit_t pend_c;
    cabe_commit_t sel_c;
    logic issue;
    logic commit_now;
    logic commit_late;
    logic commit;
    logic [10:0] a8;
    logic [16:0] w17;
    logic [15:0] prod;
    logic [15:0] rel;
    logic brw;
    logic sa;
    logic sb;

    // ********************************
    // helpers
    // ********************************
    // {h, v, c, result} of an 8-bit add or subtract
    function automatic logic [10:0] alu8(input logic [7:0] a, input logic [7:0] b,
                                         input logic cin, input logic sub);
        logic [7:0] r;
        logic h;
        logic v;
        logic c;
        r = sub ? (a - b - {7'h00, cin}) : (a + b + {7'h00, cin});
        if (sub) begin
            h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
            c = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
            v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
        end else begin
            h = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
            c = (a[7] & b[7]) | (b[7] & ~r[7]) | (~r[7] & a[7]);
            v = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
        end
        return {h, v, c, r};
    endfunction

    // zero may only stay set across a borrow chain
    function automatic logic [7:0] arith_flags(input logic [7:0] s, input logic [10:0] a,
                                               input logic keep_z);
        logic [7:0] f;
        f = s;
        f[`CABE_F_C] = a[8];
        f[`CABE_F_Z] = (a[7:0] == 8'h00) & (~keep_z | s[`CABE_F_Z]);
        f[`CABE_F_N] = a[7];
        f[`CABE_F_V] = a[9];
        f[`CABE_F_S] = a[7] ^ a[9];
        f[`CABE_F_H] = a[10];
        return f;
    endfunction

    function automatic logic [7:0] logic_flags(input logic [7:0] s, input logic [7:0] r,
                                               input logic v);
        logic [7:0] f;
        f = s;
        f[`CABE_F_Z] = (r == 8'h00);
        f[`CABE_F_N] = r[7];
        f[`CABE_F_V] = v;
        f[`CABE_F_S] = r[7] ^ v;
        return f;
    endfunction

    function automatic logic [15:0] mul16(input logic [7:0] a, input logic [7:0] b,
                                          input logic asg, input logic bsg);
        logic signed [8:0] x;
        logic signed [8:0] y;
        logic signed [17:0] p;
        x = $signed({asg & a[7], a});
        y = $signed({bsg & b[7], b});
        p = x * y;
        return p[15:0];
    endfunction

    // ********************************
    // operation decode and result
    // ********************************
    assign rel = {{4{k_i[`CABE_REL_MSB]}}, k_i[11:0]};

    always_comb begin
        next_c = '0;
        next_c.sreg = sreg_o;
        next_c.pc = pc_o + 16'h0001;
        next_c.res8 = rd_i;
        next_c.word = {rd_hi_i, rd_i};
        next_cyc = `CABE_CYC_ALU;
        a8 = 11'h000;
        w17 = 17'h00000;
        prod = 16'h0000;
        brw = 1'b0;
        sa = 1'b0;
        sb = 1'b0;
        case (op_i)
            op_add, op_add_carry: begin
                a8 = alu8(rd_i, rr_i, (op_i == op_add_carry) & sreg_o[`CABE_F_C], 1'b0);
                next_c.res8 = a8[7:0];
                next_c.sreg = arith_flags(sreg_o, a8, 1'b0);
                next_c.rd_wr = 1'b1;
            end
            op_subtract, op_subtract_constant, op_subtract_with_borrow,
            op_subtract_constant_borrow, op_compare, op_compare_with_borrow,
            op_compare_constant: begin
                brw = op_i inside {op_subtract_with_borrow, op_subtract_constant_borrow,
                                   op_compare_with_borrow};
                a8 = alu8(rd_i, (op_i inside {op_subtract_constant,
                    op_subtract_constant_borrow, op_compare_constant}) ? imm_i : rr_i,
                    brw & sreg_o[`CABE_F_C], 1'b1);
                next_c.res8 = a8[7:0];
                next_c.sreg = arith_flags(sreg_o, a8, brw);
                next_c.rd_wr = !(op_i inside {op_compare, op_compare_with_borrow,
                                              op_compare_constant});
            end
            op_arith_inverse: begin
                a8 = alu8(8'h00, rd_i, 1'b0, 1'b1);
                next_c.res8 = a8[7:0];
                next_c.sreg = arith_flags(sreg_o, a8, 1'b0);
                next_c.rd_wr = 1'b1;
            end
            op_bitwise_invert: begin
                next_c.res8 = ~rd_i;
                next_c.sreg = logic_flags(sreg_o, ~rd_i, 1'b0);
                next_c.sreg[`CABE_F_C] = 1'b1;
                next_c.rd_wr = 1'b1;
            end
            op_and, op_mask_with_constant, op_or, op_merge_with_constant,
            op_xor_registers, op_set_bits_mask, op_clear_bits_mask,
            op_test_register, op_clear_register: begin
                case (op_i)
                    op_and: next_c.res8 = rd_i & rr_i;
                    op_mask_with_constant: next_c.res8 = rd_i & imm_i;
                    op_or: next_c.res8 = rd_i | rr_i;
                    op_merge_with_constant: next_c.res8 = rd_i | imm_i;
                    op_xor_registers: next_c.res8 = rd_i ^ rr_i;
                    op_set_bits_mask: next_c.res8 = rd_i | imm_i;
                    op_clear_bits_mask: next_c.res8 = rd_i & ~imm_i;
                    op_test_register: next_c.res8 = rd_i & rd_i;
                    default: next_c.res8 = rd_i ^ rd_i;
                endcase
                next_c.sreg = logic_flags(sreg_o, next_c.res8, 1'b0);
                next_c.rd_wr = 1'b1;
            end
            op_inc, op_dec: begin
                next_c.res8 = (op_i == op_inc) ? rd_i + 8'h01 : rd_i - 8'h01;
                next_c.sreg = logic_flags(sreg_o, next_c.res8, (op_i == op_inc) ?
                    (next_c.res8 == 8'h80) : (next_c.res8 == 8'h7f));
                next_c.rd_wr = 1'b1;
            end
            op_set_all_ones: begin
                next_c.res8 = 8'hff;
                next_c.rd_wr = 1'b1;
            end
            op_add_word_immediate, op_subtract_word_immediate: begin
                next_cyc = `CABE_CYC_WORD;
                if (op_i == op_add_word_immediate) begin
                    w17 = {1'b0, rd_hi_i, rd_i} + {9'h000, imm_i};
                    next_c.sreg[`CABE_F_V] = ~rd_hi_i[7] & w17[15];
                    next_c.sreg[`CABE_F_C] = ~w17[15] & rd_hi_i[7];
                end else begin
                    w17 = {1'b0, rd_hi_i, rd_i} - {9'h000, imm_i};
                    next_c.sreg[`CABE_F_V] = rd_hi_i[7] & ~w17[15];
                    next_c.sreg[`CABE_F_C] = w17[15] & ~rd_hi_i[7];
                end
                next_c.word = w17[15:0];
                next_c.sreg[`CABE_F_Z] = (w17[15:0] == 16'h0000);
                next_c.sreg[`CABE_F_N] = w17[15];
                next_c.sreg[`CABE_F_S] = w17[15] ^ next_c.sreg[`CABE_F_V];
                next_c.word_wr = 1'b1;
            end
            op_unsigned_product, op_signed_product, op_mixed_sign_product,
            op_fractional_unsigned_product, op_fractional_signed_product,
            op_fractional_mixed_product: begin
                next_cyc = `CABE_CYC_MUL;
                sa = !(op_i inside {op_unsigned_product, op_fractional_unsigned_product});
                sb = op_i inside {op_signed_product, op_fractional_signed_product};
                prod = mul16(rd_i, rr_i, sa, sb);
                next_c.word = (op_i inside {op_fractional_unsigned_product,
                    op_fractional_signed_product, op_fractional_mixed_product}) ?
                    {prod[14:0], 1'b0} : prod;
                next_c.sreg[`CABE_F_C] = prod[15];
                next_c.sreg[`CABE_F_Z] = (next_c.word == 16'h0000);
                next_c.prod_wr = 1'b1;
            end
            op_relative_jump: begin
                next_cyc = `CABE_CYC_RELATIVE_JUMP;
                next_c.pc = pc_o + rel + 16'h0001;
            end
            op_indirect_jump_z: begin
                next_cyc = `CABE_CYC_INDIRECT_JUMP_Z;
                next_c.pc = z_i;
            end
            op_direct_jump: begin
                next_cyc = `CABE_CYC_JMP;
                next_c.pc = k_i;
            end
            op_relative_call: begin
                next_cyc = `CABE_CYC_RELATIVE_CALL;
                next_c.push = 1'b1;
                next_c.push_data = pc_o + 16'h0001;
                next_c.pc = pc_o + rel + 16'h0001;
            end
            op_indirect_call_z: begin
                next_cyc = `CABE_CYC_INDIRECT_CALL_Z;
                next_c.push = 1'b1;
                next_c.push_data = pc_o + 16'h0001;
                next_c.pc = z_i;
            end
            op_direct_call: begin
                next_cyc = `CABE_CYC_CALL;
                next_c.push = 1'b1;
                next_c.push_data = pc_o + 16'h0002;
                next_c.pc = k_i;
            end
            op_return, op_interrupt_return: begin
                next_cyc = `CABE_CYC_RET;
                next_c.pop = 1'b1;
                next_c.pc = pop_data_i;
                if (op_i == op_interrupt_return) begin
                    next_c.sreg[`CABE_F_I] = 1'b1;
                end
            end
            op_compare_skip_equal: begin
                if (rd_i == rr_i) begin
                    next_cyc = skip_two_i ? `CABE_CYC_SKIP2 : `CABE_CYC_SKIP1;
                    next_c.pc = pc_o + (skip_two_i ? 16'h0003 : 16'h0002);
                end
            end
            default: begin
                next_cyc = `CABE_CYC_ALU;
            end
        endcase
    end

    // ********************************
    // sequencing
    // ********************************
    assign ready_o = (state == st_idle);
    assign issue = ready_o & start_i;
    assign commit_now = issue & (next_cyc == `CABE_CYC_ALU);
    assign commit_late = (state == st_busy) & (cnt == 3'h0);
    assign commit = commit_now | commit_late;
    assign sel_c = commit_now ? next_c : pend_c;

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= st_idle;
            cnt <= 3'h0;
        end else begin
            case (state)
                st_idle: begin
                    if (issue && next_cyc != `CABE_CYC_ALU) begin
                        state <= st_busy;
                        cnt <= next_cyc - 3'h2;
                    end
                end
                st_busy: begin
                    if (cnt == 3'h0) begin
                        state <= st_idle;
                    end else begin
                        cnt <= cnt - 3'h1;
                    end
                end
                default: state <= st_idle;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pend_c <= '0;
        end else if (issue) begin
            pend_c <= next_c;
        end
    end

    // ********************************
    // commit
    // ********************************
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            done_o <= 1'b0;
            rd_wr_o <= 1'b0;
            word_wr_o <= 1'b0;
            prod_wr_o <= 1'b0;
            push_o <= 1'b0;
            pop_o <= 1'b0;
        end else begin
            done_o <= commit;
            rd_wr_o <= commit & sel_c.rd_wr;
            word_wr_o <= commit & sel_c.word_wr;
            prod_wr_o <= commit & sel_c.prod_wr;
            push_o <= commit & sel_c.push;
            pop_o <= commit & sel_c.pop;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_data_o <= 8'h00;
            word_data_o <= 16'h0000;
            push_data_o <= 16'h0000;
        end else if (commit) begin
            rd_data_o <= sel_c.res8;
            word_data_o <= sel_c.word;
            push_data_o <= sel_c.push_data;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sreg_o <= `CABE_SREG_RST;
            pc_o <= `CABE_PC_RST;
        end else if (commit) begin
            sreg_o <= sel_c.sreg;
            pc_o <= sel_c.pc;
        end
    end

    // ********************************
    // assertions
    // ********************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_done2; !done_o ##1 done_o; endsequence
    sequence s_done3; !done_o [*2] ##1 done_o; endsequence
    sequence s_done4; !done_o [*3] ##1 done_o; endsequence

    property p_add;
        issue && op_i == op_add |=> done_o && rd_data_o == $past(rd_i) + $past(rr_i);
    endproperty
    a_add: assert property (p_add) else $error("add result wrong");
    property p_word;
        issue && op_i == op_add_word_immediate |=> s_done2 ##0
            (word_wr_o && word_data_o == $past({rd_hi_i, rd_i}, 2) + {8'h00, $past(imm_i, 2)});
    endproperty
    a_word: assert property (p_word) else $error("word add wrong");
    property p_wsub;
        issue && op_i == op_subtract_word_immediate && {rd_hi_i, rd_i} < {8'h00, imm_i}
            |=> s_done2 ##0 sreg_o[`CABE_F_C];
    endproperty
    a_wsub: assert property (p_wsub) else $error("word borrow lost");
    property p_sub;
        issue && op_i == op_subtract && rd_i < rr_i |=> done_o && sreg_o[`CABE_F_C];
    endproperty
    a_sub: assert property (p_sub) else $error("subtract borrow lost");
    property p_sbc;
        issue && op_i == op_subtract_with_borrow |=>
            rd_data_o == $past(rd_i) - $past(rr_i) - {7'h00, $past(sreg_o[`CABE_F_C])};
    endproperty
    a_sbc: assert property (p_sbc) else $error("borrow not used");
    property p_logic;
        issue && op_i == op_and |=> done_o && !sreg_o[`CABE_F_V] &&
            sreg_o[`CABE_F_C] == $past(sreg_o[`CABE_F_C]);
    endproperty
    a_logic: assert property (p_logic) else $error("logic flags wrong");
    property p_clrmask;
        issue && op_i == op_clear_bits_mask |=> rd_data_o == ($past(rd_i) & ~$past(imm_i));
    endproperty
    a_clrmask: assert property (p_clrmask) else $error("mask clear wrong");
    property p_ones;
        issue && op_i == op_set_all_ones |=> rd_data_o == 8'hff && sreg_o == $past(sreg_o);
    endproperty
    a_ones: assert property (p_ones) else $error("set ones wrong");
    property p_mul;
        issue && op_i == op_unsigned_product |=> s_done2 ##0 (prod_wr_o &&
            word_data_o == {8'h00, $past(rd_i, 2)} * {8'h00, $past(rr_i, 2)});
    endproperty
    a_mul: assert property (p_mul) else $error("product wrong");
    property p_indirect_jump_z;
        issue && op_i == op_indirect_jump_z |=> s_done2 ##0 pc_o == $past(z_i, 2);
    endproperty
    a_indirect_jump_z: assert property (p_indirect_jump_z) else $error("indirect jump wrong");
    property p_indirect_call_z;
        issue && op_i == op_indirect_call_z |=> s_done3 ##0 (push_o && pc_o == $past(z_i, 3));
    endproperty
    a_indirect_call_z: assert property (p_indirect_call_z) else $error("indirect call wrong");
    property p_noskip;
        issue && op_i == op_compare_skip_equal && rd_i != rr_i |=>
            done_o && pc_o == $past(pc_o) + 16'h0001;
    endproperty
    a_noskip: assert property (p_noskip) else $error("false skip");
    property p_cmp;
        issue && op_i == op_compare |=> done_o && !rd_wr_o;
    endproperty
    a_cmp: assert property (p_cmp) else $error("compare stored");
    property p_interrupt_return;
        issue && op_i == op_interrupt_return |=> s_done4 ##0 (pop_o && sreg_o[`CABE_F_I]);
    endproperty
    a_interrupt_return: assert property (p_interrupt_return) else $error("return wrong");
endmodule

// ---- pkg/cabe_regs.svh ----
// Purpose: flag positions, reset values and cycle counts of the execute block
// Assumes: status byte layout C Z N V S H T I from bit 0 upward
// Notes: definitions only
`ifndef CABE_REGS_SVH
`define CABE_REGS_SVH
`define CABE_F_C 0
`define CABE_F_Z 1
`define CABE_F_N 2
`define CABE_F_V 3
`define CABE_F_S 4
`define CABE_F_H 5
`define CABE_F_I 7
`define CABE_SREG_RST 8'h00
`define CABE_PC_RST 16'h0000
`define CABE_REL_MSB 11
`define CABE_CYC_ALU 3'h1
`define CABE_CYC_WORD 3'h2
`define CABE_CYC_MUL 3'h2
`define CABE_CYC_RELATIVE_JUMP 3'h2
`define CABE_CYC_INDIRECT_JUMP_Z 3'h2
`define CABE_CYC_JMP 3'h3
`define CABE_CYC_RELATIVE_CALL 3'h3
`define CABE_CYC_INDIRECT_CALL_Z 3'h3
`define CABE_CYC_CALL 3'h4
`define CABE_CYC_RET 3'h4
`define CABE_CYC_SKIP1 3'h2
`define CABE_CYC_SKIP2 3'h3
`endif

// ---- pkg/cabe_pkg.sv ----
// Purpose: types of the execute block
// Assumes: the decoder drives one cabe_op_t per operation
// Notes: operation encoding is free for the decoder to use
package cabe_pkg;
    typedef enum logic [5:0] {
        op_add, op_add_carry, op_add_word_immediate, op_subtract,
        op_subtract_constant, op_subtract_with_borrow, op_subtract_constant_borrow,
        op_subtract_word_immediate, op_and, op_mask_with_constant, op_or,
        op_merge_with_constant, op_xor_registers, op_bitwise_invert, op_arith_inverse,
        op_set_bits_mask, op_clear_bits_mask, op_inc, op_dec, op_test_register,
        op_clear_register, op_set_all_ones, op_unsigned_product, op_signed_product,
        op_mixed_sign_product, op_fractional_unsigned_product,
        op_fractional_signed_product, op_fractional_mixed_product, op_relative_jump,
        op_indirect_jump_z, op_direct_jump, op_relative_call, op_indirect_call_z,
        op_direct_call, op_return, op_interrupt_return, op_compare_skip_equal,
        op_compare, op_compare_with_borrow, op_compare_constant
    } cabe_op_t;
    typedef enum logic {
        st_idle = 1'b0,
        st_busy = 1'b1
    } cabe_state_t;
    typedef struct packed {
        logic [7:0] res8;
        logic [15:0] word;
        logic [7:0] sreg;
        logic [15:0] pc;
        logic [15:0] push_data;
        logic rd_wr;
        logic word_wr;
        logic prod_wr;
        logic push;
        logic pop;
    } cabe_commit_t;
endpackage

// ---- dv/cabe_stack_model.sv ----
// Purpose: return stack beside the execute block
// Assumes: push and pop strobes last one cycle
// Notes: empty stack reads a fixed pattern
`timescale 1ns/100ps
module cabe_stack_model (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic push_i,
    input wire logic [15:0] push_data_i,
    input wire logic pop_i,
    output logic [15:0] top_o
);
    logic [15:0] stk [0:7];
    logic [2:0] sp;
    logic [2:0] lvl;
    // forward a push or pop in flight, so a return issued at that edge sees the new top
    assign lvl = pop_i ? sp - 3'h1 : sp;
    assign top_o = push_i ? push_data_i : (lvl == 3'h0) ? 16'ha5a5 : stk[lvl - 3'h1];
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sp <= 3'h0;
        end else if (push_i) begin
            stk[sp] <= push_data_i;
            sp <= sp + 3'h1;
        end else if (pop_i) begin
            sp <= sp - 3'h1;
        end
    end
endmodule

// ---- dv/tb_cpu_alu_branch_exec.sv ----
// Purpose: directed checks of the execute block
// Assumes: inputs change on the falling edge
// Notes: pc checked after relative jump and call, returns, indirect jump and skips, not after the absolute jump
`timescale 1ns/100ps
`define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin errors++; \
    $display("mismatch %s exp %h got %h", nm, e, s); end end
module tb_cpu_alu_branch_exec import cabe_pkg::*;;
    logic sys_clk_i, reset_n_i, start_i, skip_two_i, ready_o, done_o, rd_wr_o;
    logic word_wr_o, prod_wr_o, push_o, pop_o;
    cabe_op_t op_i;
    logic [7:0] rd_i, rr_i, rd_hi_i, imm_i, rd_data_o, sreg_o;
    logic [15:0] k_i, z_i, pop_data_i, word_data_o, push_data_o, pc_o;
    int errors = 0, samples_checked = 0, cyc = 0;
    cabe_core cabe_core_inst (.sys_clk_i, .reset_n_i, .start_i, .op_i, .rd_i, .rr_i,
        .rd_hi_i, .imm_i, .k_i, .z_i, .pop_data_i, .skip_two_i, .ready_o, .done_o,
        .rd_wr_o, .rd_data_o, .word_wr_o, .prod_wr_o, .word_data_o, .push_o,
        .push_data_o, .pop_o, .sreg_o, .pc_o);
    cabe_stack_model cabe_stack_model_inst (.sys_clk_i, .reset_n_i, .push_i(push_o),
        .push_data_i(push_data_o), .pop_i(pop_o), .top_o(pop_data_i));
    initial begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end
    task automatic end_sim();
        if (errors == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            errors++;
            end_sim();
        end
    end
    // ****************************
    // issue one operation, count cycles
    // ****************************
    task automatic run(input cabe_op_t o, input logic [7:0] a, input logic [7:0] b,
                       input int n, input logic hold);
        int c;
        op_i = o;
        rd_i = a;
        rr_i = b;
        imm_i = b;
        start_i = 1'b1;
        @(negedge sys_clk_i);
        c = 1;
        `CHK("ready", (n == 1), ready_o)
        // one-cycle ops leave start_i up so the next call issues back to back
        if (done_o !== 1'b1) start_i = hold;
        while (done_o !== 1'b1 && c < 8) begin
            @(negedge sys_clk_i);
            c++;
            if (hold || done_o !== 1'b1) start_i = 1'b0;
        end
        `CHK("cycles", n, c)
    endtask
    task automatic t_arith();
        run(op_add, 8'hff, 8'h01, 1, 1'b0);
        `CHK("add", 8'h00, rd_data_o)
        `CHK("addf", 8'h23, sreg_o & 8'h23)
        run(op_add_carry, 8'h10, 8'h20, 1, 1'b0);
        `CHK("adc", 8'h31, rd_data_o)
        run(op_subtract_constant, 8'h00, 8'h01, 1, 1'b0);
        `CHK("subf", 8'h05, sreg_o & 8'h05)
        run(op_subtract_with_borrow, 8'h05, 8'h03, 1, 1'b0);
        `CHK("sbc", 8'h01, rd_data_o)
        run(op_compare, 8'h10, 8'h20, 1, 1'b0);
        `CHK("cpwr", 1'b0, rd_wr_o)
        `CHK("cpf", 8'h05, sreg_o & 8'h05)
        run(op_xor_registers, 8'haa, 8'haa, 1, 1'b0);
        `CHK("xorf", 8'h03, sreg_o & 8'h0b)
        run(op_clear_bits_mask, 8'hff, 8'h0f, 1, 1'b0);
        `CHK("cbr", 8'hf0, rd_data_o)
        run(op_bitwise_invert, 8'h55, 8'h00, 1, 1'b0);
        `CHK("com", 8'haa, rd_data_o)
        run(op_arith_inverse, 8'h01, 8'h00, 1, 1'b0);
        `CHK("neg", 8'hff, rd_data_o)
        run(op_set_all_ones, 8'h12, 8'h00, 1, 1'b0);
        `CHK("ser", 8'hff, rd_data_o)
        `CHK("serf", 8'h35, sreg_o)
    endtask
    task automatic t_logic();
        run(op_subtract, 8'h01, 8'h02, 1, 1'b0);
        `CHK("sub", 8'hff, rd_data_o)
        run(op_and, 8'hf0, 8'h3c, 1, 1'b0);
        `CHK("andf", 8'h21, sreg_o)
        run(op_merge_with_constant, 8'h01, 8'h80, 1, 1'b0);
        `CHK("ori", 8'h81, rd_data_o)
        run(op_inc, 8'h7f, 8'h00, 1, 1'b0);
        `CHK("incf", 8'h2d, sreg_o)
        run(op_dec, 8'h00, 8'h00, 1, 1'b0);
        `CHK("dec", 8'hff, rd_data_o)
        run(op_test_register, 8'h00, 8'h00, 1, 1'b0);
        `CHK("tstf", 8'h23, sreg_o)
        run(op_compare_with_borrow, 8'h01, 8'h00, 1, 1'b0);
        `CHK("cpcf", 8'h02, sreg_o)
        run(op_compare_constant, 8'h00, 8'h01, 1, 1'b0);
        `CHK("cpif", 8'h35, sreg_o)
        run(op_subtract_constant_borrow, 8'h10, 8'h01, 1, 1'b0);
        `CHK("subtract_constant_borrow", 8'h0e, rd_data_o)
        run(op_mask_with_constant, 8'h0f, 8'h3c, 1, 1'b0);
        `CHK("mask_with_constant", 8'h0c, rd_data_o)
        run(op_or, 8'h0f, 8'hf0, 1, 1'b0);
        `CHK("or", 8'hff, rd_data_o)
        run(op_set_bits_mask, 8'h01, 8'h06, 1, 1'b0);
        `CHK("sbr", 8'h07, rd_data_o)
        run(op_clear_register, 8'h5a, 8'h00, 1, 1'b0);
        `CHK("clrf", 8'h22, sreg_o)
    endtask
    task automatic t_word_mul();
        rd_hi_i = 8'h00;
        run(op_add_word_immediate, 8'hff, 8'h01, 2, 1'b0);
        `CHK("add_word_immediate", 16'h0100, word_data_o)
        `CHK("adiwwr", 1'b1, word_wr_o)
        run(op_subtract_word_immediate, 8'h00, 8'h01, 2, 1'b0);
        `CHK("subtract_word_immediate", 16'hffff, word_data_o)
        run(op_unsigned_product, 8'hff, 8'hff, 2, 1'b1);
        `CHK("mul", 16'hfe01, word_data_o)
        `CHK("mulwr", 1'b1, prod_wr_o)
        @(negedge sys_clk_i);
        `CHK("refused", 1'b0, done_o)
        run(op_mixed_sign_product, 8'hff, 8'h02, 2, 1'b0);
        `CHK("mixed_sign_product", 16'hfffe, word_data_o)
        run(op_signed_product, 8'hfe, 8'h03, 2, 1'b0);
        `CHK("signed_product", 16'hfffa, word_data_o)
        run(op_fractional_unsigned_product, 8'hff, 8'hff, 2, 1'b0);
        `CHK("fractional_unsigned_product", 16'hfc02, word_data_o)
        `CHK("fmulc", 1'b1, sreg_o[0])
        run(op_fractional_signed_product, 8'h80, 8'h80, 2, 1'b0);
        `CHK("fractional_signed_product", 16'h8000, word_data_o)
        run(op_fractional_mixed_product, 8'hff, 8'h80, 2, 1'b0);
        `CHK("fractional_mixed_product", 16'hff00, word_data_o)
    endtask
    task automatic t_flow();
        k_i = 16'h0100;
        run(op_direct_jump, 8'h00, 8'h00, 3, 1'b0);
        k_i = 16'h0005;
        run(op_relative_jump, 8'h00, 8'h00, 2, 1'b0);
        `CHK("relative_jump", 16'h0106, pc_o)
        z_i = 16'h0200;
        run(op_indirect_call_z, 8'h00, 8'h00, 3, 1'b0);
        `CHK("icpush", 16'h0107, push_data_o)
        k_i = 16'h0300;
        run(op_direct_call, 8'h00, 8'h00, 4, 1'b0);
        `CHK("cpush", 16'h0202, push_data_o)
        run(op_return, 8'h00, 8'h00, 4, 1'b0);
        `CHK("ret", 16'h0202, pc_o)
        `CHK("pop", 1'b1, pop_o)
        run(op_interrupt_return, 8'h00, 8'h00, 4, 1'b0);
        `CHK("interrupt_return", 16'h0107, pc_o)
        `CHK("ien", 1'b1, sreg_o[7])
        z_i = 16'h0400;
        run(op_indirect_jump_z, 8'h00, 8'h00, 2, 1'b0);
        `CHK("indirect_jump_z", 16'h0400, pc_o)
        run(op_compare_skip_equal, 8'h33, 8'h33, 2, 1'b0);
        skip_two_i = 1'b1;
        run(op_compare_skip_equal, 8'h33, 8'h33, 3, 1'b0);
        run(op_compare_skip_equal, 8'h33, 8'h34, 1, 1'b0);
        `CHK("skip", 16'h0406, pc_o)
        k_i = 16'h0ffe;
        run(op_relative_call, 8'h00, 8'h00, 3, 1'b0);
        `CHK("relative_call", 16'h0405, pc_o)
        `CHK("rcpush", 16'h0407, push_data_o)
    endtask
    initial begin
        {reset_n_i, start_i, skip_two_i, rd_i, rr_i, rd_hi_i, imm_i, k_i, z_i} = '0;
        op_i = op_add;
        repeat (8) @(negedge sys_clk_i);
        reset_n_i = 1'b1;
        t_arith();
        t_logic();
        t_word_mul();
        t_flow();
        end_sim();
    end
endmodule
